// >>> sim_pkg.sv
// system integrity monitor: shared constants, types and helpers
//------------------------------------------------------------
// Notes on behaviour
// RQ1 - with pll on, too-close main oscillator edges are dropped; pll off passes all
// RQ2 - main oscillator lost: cpu clock taken from the safe oscillator
// RQ3 - main oscillator back: cpu clock returns to it by itself
// RQ4 - on safe oscillator the loss flag sets; interrupt if its enable is set
// RQ5 - wait mode changes nothing; both interrupts wake from wait
// RQ6 - halt freezes source state and turns off clock security and safe oscillator
// RQ7 - leaving halt by interrupt keeps setup; a reset restarts from reset values
// RQ8 - neither loss nor supply warning can wake from halt
// RQ9 - interrupt only with own enable set and cpu global mask clear
// RQ10 - warning enable bit 6 read/write; each flag change posts, cleared at isr
// RQ11 - warning flag bit 5 read-only; one when supply below warning threshold
// RQ12 - undervoltage reset flag bit 4 set by that reset, cleared by writing zero
// RQ13 - software writes zero to reserved bit 3
// RQ14 - loss enable bit 2 read/write, no effect with clock security off
// RQ15 - loss flag bit 1 set on safe oscillator, read clears after recovery
// RQ16 - with clock security off the loss flag reads zero
// RQ17 - watchdog flag bit 0 set by watchdog reset, cleared by zero write or uv reset
// RQ18 - cause pair: pin 0/0, watchdog 0/1, undervoltage 1/x
// RQ19 - pin or watchdog reset leaves the undervoltage flag as it was
// RQ20 - warning flag and interrupt work only with the uv detector enabled
// RQ21 - loss interrupt is a level while flag and enable are both one
//------------------------------------------------------------
package sim_pkg;
   //------------------------------------------------------------
   // timing
   //------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   // least time without an edge before the main oscillator counts as lost
   localparam int LOSS_TIME_NS = 1000;
   localparam int LOSS_CYC = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // least spacing between two genuine oscillator edges while the pll runs
   localparam int GLITCH_GAP_NS = 120;
   localparam int GLITCH_CYC = (GLITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_EDGES = 4;
   localparam int CNT_W = 8;

   //------------------------------------------------------------
   // register map
   //------------------------------------------------------------
   localparam logic [7:0] ADDR_CSR = 8'h00;
   localparam logic [7:0] CSR_RESET = 8'h00;

   typedef struct packed {
      logic rsvd_hi;
      logic warn_ie;
      logic warn_flag;
      logic uv_rf;
      logic rsvd;
      logic loss_ie;
      logic loss_det;
      logic wdg_rf;
   } sim_csr_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sim_bus_t;

   typedef enum logic [0:0] {
      SRC_MAIN = 1'b0,
      SRC_SAFE = 1'b1
   } sim_src_t;

   function automatic logic sim_hit(input logic [7:0] addr);
      sim_hit = (addr == ADDR_CSR);
   endfunction : sim_hit
endpackage : sim_pkg

// >>> sim_osc_filter.sv
// system integrity monitor: main oscillator edge filter
`timescale 1ns/1ns
module sim_osc_filter (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // oscillator side
   input wire logic osc_in,
   input wire logic pll_enable,
   // filtered edge
   output logic edge_ok
);
   logic osc_prev;
   logic [sim_pkg::CNT_W-1:0] gap;
   logic rise;
   logic accept;

   assign rise = osc_in & ~osc_prev;
   // RQ1 spacing filter, pll only
   assign accept = rise & (~pll_enable | (gap >= sim_pkg::CNT_W'(sim_pkg::GLITCH_CYC)));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= osc_in;
      end
   end

   // saturating so a long quiet spell never wraps into a false short gap
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap <= '1;
      end else if (accept) begin
         gap <= 8'h01;
      end else if (gap != '1) begin
         gap <= gap + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_ok <= 1'b0;
      end else begin
         edge_ok <= accept;
      end
   end

   // RQ1 no filtering with pll off
   chk_filter_pll_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!pll_enable && rise) |=> edge_ok) else $error("edge dropped with pll off");
endmodule : sim_osc_filter

// >>> sim_clk_watch.sv
// system integrity monitor: main oscillator loss detector
`timescale 1ns/1ns
module sim_clk_watch (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic edge_ok,
   // status
   output logic lost
);
   logic [sim_pkg::CNT_W-1:0] idle;
   logic [sim_pkg::CNT_W-1:0] good;

   // frozen while not running, so halt keeps the detector where it was
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle <= '0;
         good <= '0;
         lost <= 1'b0;
      end else if (run) begin
         if (edge_ok) begin
            idle <= '0;
            if (lost) begin
               // RQ3 recovery after steady edges
               if (good == sim_pkg::CNT_W'(sim_pkg::RECOVER_EDGES - 1)) begin
                  lost <= 1'b0;
                  good <= '0;
               end else begin
                  good <= good + 8'h01;
               end
            end
         end else begin
            if (idle != '1) begin
               idle <= idle + 8'h01;
            end
            // RQ2 loss after quiet spell; only a new loss restarts recovery
            if (idle == sim_pkg::CNT_W'(sim_pkg::LOSS_CYC - 1)) begin
               lost <= 1'b1;
               good <= '0;
            end
         end
      end
   end
endmodule : sim_clk_watch

// >>> sim_top.sv
// system integrity monitor: clock security, supply warning and reset cause
`timescale 1ns/1ns
module sim_top (
   // clock and resets
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic por_n,
   // register port
   input wire sim_pkg::sim_bus_t bus,
   output logic [7:0] reg_rdata,
   // option configuration
   input wire logic opt_css_enable,
   input wire logic opt_uvd_enable,
   input wire logic pll_enable,
   // cause of the reset now ending, held stable around release
   input wire logic cause_uv,
   input wire logic cause_wdg,
   // oscillator and supply comparator
   input wire logic main_osc_sample,
   input wire logic supply_below,
   // power modes
   input wire logic wait_mode,
   input wire logic halt_mode,
   // cpu interrupt side
   input wire logic global_mask,
   input wire logic warn_isr_enter,
   // outputs
   output logic cpu_clk_on_safe,
   output logic safe_osc_enable,
   output logic main_osc_edge,
   output logic irq_clock_loss,
   output logic irq_supply_warn,
   output logic wake_from_wait
);
   //------------------------------------------------------------
   // declarations
   //------------------------------------------------------------
   sim_pkg::sim_src_t src;
   sim_pkg::sim_src_t next_src;
   sim_pkg::sim_csr_t csr;
   logic started;
   logic css_on;
   logic run;
   logic edge_ok;
   logic lost;
   logic wr_hit;
   logic rd_hit;
   logic warn_ie;
   logic loss_ie;
   logic warn_flag;
   logic next_warn_flag;
   logic warn_pend;
   logic loss_det;
   logic uv_rf;
   logic wdg_rf;
   logic loss_req;
   logic warn_req;

   assign css_on = opt_css_enable;
   // RQ6 security stops in halt
   assign run = css_on & ~halt_mode;
   assign wr_hit = bus.wr & sim_pkg::sim_hit(bus.addr);
   assign rd_hit = bus.rd & sim_pkg::sim_hit(bus.addr);

   //------------------------------------------------------------
   // oscillator filter and loss detector
   //------------------------------------------------------------
   sim_osc_filter u_filter (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .osc_in(main_osc_sample),
      .pll_enable(pll_enable),
      .edge_ok(edge_ok)
   );

   sim_clk_watch u_watch (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .run(run),
      .edge_ok(edge_ok),
      .lost(lost)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_osc_edge <= 1'b0;
      end else begin
         main_osc_edge <= edge_ok;
      end
   end

   //------------------------------------------------------------
   // clock source selection
   //------------------------------------------------------------
   always_comb begin
      next_src = src;
      if (!css_on) begin
         next_src = sim_pkg::SRC_MAIN;
      end else if (!halt_mode) begin
         unique case (src)
            // RQ2 switch to safe
            sim_pkg::SRC_MAIN: begin
               if (lost) begin
                  next_src = sim_pkg::SRC_SAFE;
               end
            end
            // RQ3 automatic return
            sim_pkg::SRC_SAFE: begin
               if (!lost) begin
                  next_src = sim_pkg::SRC_MAIN;
               end
            end
         endcase
      end
   end

   // RQ7 halt keeps state; only reset restarts it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         src <= sim_pkg::SRC_MAIN;
      end else begin
         src <= next_src;
      end
   end

   // RQ6 safe oscillator off in halt
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         safe_osc_enable <= 1'b0;
         cpu_clk_on_safe <= 1'b0;
      end else begin
         safe_osc_enable <= ~halt_mode & (next_src == sim_pkg::SRC_SAFE);
         cpu_clk_on_safe <= ~halt_mode & (next_src == sim_pkg::SRC_SAFE);
      end
   end

   //------------------------------------------------------------
   // reset cause capture
   //------------------------------------------------------------
   // causes are sampled one clock after release; the uv cause also on every clock while rst_n is low
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         started <= 1'b0;
      end else begin
         started <= 1'b1;
      end
   end

   // RQ17 watchdog flag: set, zero write, uv clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdg_rf <= 1'b0;
      end else if (!started) begin
         // RQ18 uv reset wins over watchdog
         wdg_rf <= cause_wdg & ~cause_uv;
      end else if (wr_hit && !bus.wdata[0]) begin
         wdg_rf <= 1'b0;
      end
   end

   // RQ19 of the resets only power-on clears this, so system resets keep it
   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         uv_rf <= 1'b0;
      end else if (!started && cause_uv) begin
         // RQ12 set by uv reset
         uv_rf <= 1'b1;
      end else if (started && wr_hit && !bus.wdata[4]) begin
         uv_rf <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // software enables
   //------------------------------------------------------------
   // RQ10 RQ14 enables read/write; reserved bit 3 never stored
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         warn_ie <= 1'b0;
         loss_ie <= 1'b0;
      end else if (wr_hit) begin
         warn_ie <= bus.wdata[6];
         loss_ie <= bus.wdata[2];
      end
   end

   //------------------------------------------------------------
   // clock loss flag
   //------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         loss_det <= 1'b0;
      end else if (!css_on) begin
         // RQ16 forced zero
         loss_det <= 1'b0;
      end else if (src == sim_pkg::SRC_SAFE) begin
         // RQ4 set on safe, set beats read
         loss_det <= 1'b1;
      end else if (rd_hit) begin
         // RQ15 read clears after recovery
         loss_det <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // supply warning flag and pending request
   //------------------------------------------------------------
   // RQ20 RQ11 comparator only with uv detector
   assign next_warn_flag = opt_uvd_enable & supply_below;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         warn_flag <= 1'b0;
      end else begin
         warn_flag <= next_warn_flag;
      end
   end

   // RQ10 post on every flag change while warn_ie is set, set beats isr clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         warn_pend <= 1'b0;
      end else if (warn_ie && (next_warn_flag != warn_flag)) begin
         warn_pend <= 1'b1;
      end else if (warn_isr_enter) begin
         warn_pend <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // interrupt requests
   //------------------------------------------------------------
   // RQ9 RQ14 RQ21 level request, gated by enable, mask, config
   assign loss_req = loss_det & loss_ie & css_on & ~global_mask;
   assign warn_req = warn_pend & warn_ie & opt_uvd_enable & ~global_mask;

   // RQ8 never raised in halt, so halt is not left by these
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_clock_loss <= 1'b0;
         irq_supply_warn <= 1'b0;
      end else begin
         irq_clock_loss <= loss_req & ~halt_mode;
         irq_supply_warn <= warn_req & ~halt_mode;
      end
   end

   // RQ5 both requests wake from wait
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_from_wait <= 1'b0;
      end else begin
         wake_from_wait <= wait_mode & ~halt_mode & (loss_req | warn_req);
      end
   end

   //------------------------------------------------------------
   // register read
   //------------------------------------------------------------
   always_comb begin
      csr = sim_pkg::CSR_RESET;
      csr.warn_ie = warn_ie;
      csr.warn_flag = warn_flag;
      csr.uv_rf = uv_rf;
      csr.loss_ie = loss_ie;
      csr.loss_det = loss_det;
      csr.wdg_rf = wdg_rf;
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (rd_hit) begin
         reg_rdata <= csr;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   chk_safe_on_loss: assert property ( // RQ2
      @(posedge core_clk) disable iff (!rst_n)
      (lost && css_on && !halt_mode && src == sim_pkg::SRC_MAIN)
      |=> src == sim_pkg::SRC_SAFE && cpu_clk_on_safe)
      else $error("no switch to safe oscillator");

   chk_return_main: assert property ( // RQ3
      @(posedge core_clk) disable iff (!rst_n)
      (src == sim_pkg::SRC_SAFE && !lost && !halt_mode) |=> src == sim_pkg::SRC_MAIN)
      else $error("no return to main oscillator");

   chk_loss_flag_set: assert property ( // RQ4
      @(posedge core_clk) disable iff (!rst_n)
      (src == sim_pkg::SRC_SAFE && css_on) |=> loss_det)
      else $error("loss flag not set on safe clock");

   chk_halt_safe_off: assert property ( // RQ6
      @(posedge core_clk) disable iff (!rst_n)
      halt_mode |=> !safe_osc_enable && $stable(src))
      else $error("safe oscillator runs in halt");

   chk_halt_no_irq: assert property ( // RQ8
      @(posedge core_clk) disable iff (!rst_n)
      halt_mode |=> !irq_clock_loss && !irq_supply_warn && !wake_from_wait)
      else $error("request raised in halt");

   chk_mask_gate: assert property ( // RQ9
      @(posedge core_clk) disable iff (!rst_n)
      global_mask |=> !irq_clock_loss && !irq_supply_warn)
      else $error("request passed the global mask");

   chk_warn_post: assert property ( // RQ10
      @(posedge core_clk) disable iff (!rst_n)
      (warn_ie && next_warn_flag != warn_flag) |=> warn_pend ##1 (warn_pend || $past(warn_isr_enter)))
      else $error("warning change not posted");

   chk_loss_zero: assert property ( // RQ16
      @(posedge core_clk) disable iff (!rst_n)
      !opt_css_enable |=> !loss_det && !irq_clock_loss[*1])
      else $error("loss flag set with security off");

   chk_wdg_clear: assert property ( // RQ17
      @(posedge core_clk) disable iff (!rst_n)
      (started && wr_hit && !bus.wdata[0]) |=> !wdg_rf)
      else $error("watchdog flag not cleared");

   chk_loss_irq_level: assert property ( // RQ21
      @(posedge core_clk) disable iff (!rst_n)
      (loss_det && loss_ie && css_on && !global_mask && !halt_mode) |=> irq_clock_loss)
      else $error("loss request not asserted");

   chk_read_once: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !rd_hit |=> reg_rdata == 8'h00)
      else $error("read data outside its cycle");

   cov_safe_cycle: cover property (@(posedge core_clk) disable iff (!rst_n)
      src == sim_pkg::SRC_SAFE ##[1:1000] src == sim_pkg::SRC_MAIN);
   cov_warn_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
      $rose(irq_supply_warn));
   cov_wait_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
      $rose(wake_from_wait));
endmodule : sim_top

// >>> sim_partner.sv
// system integrity monitor: main oscillator and supply comparator model
`timescale 1ns/1ns
module sim_partner (
   // clock
   input wire logic core_clk,
   // controls from the bench
   input wire logic osc_run,
   input wire logic osc_glitch,
   input wire logic vdd_low,
   // toward the block
   output logic main_osc_sample,
   output logic supply_below
);
   //------------------------------------------------------------
   // oscillator: period of eight core cycles, high for four
   //------------------------------------------------------------
   logic [2:0] phase = 3'h0;
   initial main_osc_sample = 1'b0;
   initial supply_below = 1'b0;
   always @(posedge core_clk) begin
      phase <= osc_run ? phase + 3'h1 : 3'h0;
      // a one-sample dropout just after the rising edge makes a spike edge two cycles on
      main_osc_sample <= osc_run & phase[2] & ~(osc_glitch & (phase == 3'h5));
      // a dead resonator holds low rather than floating
      supply_below <= vdd_low;
   end
endmodule : sim_partner

// >>> sim_top_test.sv
// system integrity monitor: self-checking bench with a behavioural register model
`timescale 1ns/1ns
module sim_top_test;
   //------------------------------------------------------------
   // signals
   //------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   sim_pkg::sim_bus_t bus = '0;
   logic [7:0] reg_rdata;
   logic opt_css_enable = 1'b0;
   logic opt_uvd_enable = 1'b1;
   logic pll_enable = 1'b0;
   logic cause_uv = 1'b0;
   logic cause_wdg = 1'b0;
   logic main_osc_sample, supply_below;
   logic wait_mode = 1'b0;
   logic halt_mode = 1'b0;
   logic global_mask = 1'b0;
   logic warn_isr_enter = 1'b0;
   logic cpu_clk_on_safe, safe_osc_enable, main_osc_edge;
   logic irq_clock_loss, irq_supply_warn, wake_from_wait;
   logic osc_run = 1'b1;
   logic osc_glitch = 1'b0;
   logic vdd_low = 1'b0;
   logic [1:0] cause_tab [5] = '{2'b01, 2'b11, 2'b01, 2'b00, 2'b10};
   int error_cnt = 0;
   int n_compared = 0;
   int m_csr = 0;
   int n;
   int cnt;

   always #20 core_clk = ~core_clk;

   sim_top DUT (.core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .bus(bus),
      .reg_rdata(reg_rdata), .opt_css_enable(opt_css_enable),
      .opt_uvd_enable(opt_uvd_enable), .pll_enable(pll_enable), .cause_uv(cause_uv),
      .cause_wdg(cause_wdg), .main_osc_sample(main_osc_sample),
      .supply_below(supply_below), .wait_mode(wait_mode), .halt_mode(halt_mode),
      .global_mask(global_mask), .warn_isr_enter(warn_isr_enter),
      .cpu_clk_on_safe(cpu_clk_on_safe), .safe_osc_enable(safe_osc_enable),
      .main_osc_edge(main_osc_edge), .irq_clock_loss(irq_clock_loss),
      .irq_supply_warn(irq_supply_warn), .wake_from_wait(wake_from_wait));

   sim_partner u_osc (.core_clk(core_clk), .osc_run(osc_run), .osc_glitch(osc_glitch),
      .vdd_low(vdd_low), .main_osc_sample(main_osc_sample), .supply_below(supply_below));

   //------------------------------------------------------------
   // compare, bus and reset tasks
   //------------------------------------------------------------
   task automatic check8(input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : check8

   task automatic check1(input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : check1

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge core_clk);
      bus.addr <= addr;
      bus.rd <= 1'b1;
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1 check8(exp, reg_rdata);
   endtask : rd_chk

   task automatic wr(input logic [7:0] addr, input logic [7:0] d);
      @(posedge core_clk);
      bus.addr <= addr;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge core_clk);
      bus.wr <= 1'b0;
      // flags only clear on a zero, status bits ignore the write
      if (addr === sim_pkg::ADDR_CSR) m_csr = (m_csr & 'h22) | (m_csr & d & 'h11) | (d & 'h44);
   endtask : wr

   task automatic do_reset(input logic uv, input logic wdg);
      @(posedge core_clk);
      cause_uv <= uv;
      cause_wdg <= wdg;
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      m_csr = (m_csr & 'h30) | (uv ? 'h10 : 0) | ((wdg & ~uv) ? 'h01 : 0);
   endtask : do_reset

   task automatic pulse_isr();
      @(posedge core_clk);
      warn_isr_enter <= 1'b1;
      @(posedge core_clk);
      warn_isr_enter <= 1'b0;
   endtask : pulse_isr

   task automatic test_done(input string s);
      $display("test %s done", s);
   endtask : test_done

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   //------------------------------------------------------------
   // watchdog: the whole sequence needs well under a thousand cycles
   //------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      end_sim();
   end

   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial begin
      n = $urandom(51122);
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd_chk(sim_pkg::ADDR_CSR, sim_pkg::CSR_RESET);
      n = 1 + ($urandom % 255);
      wr(n[7:0], 8'h44);
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      rd_chk(n[7:0], 8'h00);
      test_done("registers");

      // spike edges pass with the pll off and are dropped with it on
      for (int p = 0; p < 2; p++) begin
         @(posedge core_clk);
         pll_enable <= p[0];
         osc_glitch <= 1'b1;
         repeat (16) @(posedge core_clk);
         cnt = 0;
         repeat (64) begin
            @(posedge core_clk);
            #1 cnt += (main_osc_edge === 1'b1);
         end
         check8(p ? 8'h08 : 8'h10, cnt[7:0]);
      end
      @(posedge core_clk);
      osc_glitch <= 1'b0;
      pll_enable <= 1'b0;
      test_done("filter");

      @(posedge core_clk);
      osc_run <= 1'b0;
      repeat (40) @(posedge core_clk);
      #1 check1(1'b0, cpu_clk_on_safe);
      wr(sim_pkg::ADDR_CSR, 8'h04);
      repeat (3) @(posedge core_clk);
      #1 check1(1'b0, irq_clock_loss);
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      test_done("css_off");

      @(posedge core_clk);
      opt_css_enable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (cpu_clk_on_safe !== 1'b1 && n < 100);
      check1(1'b1, n >= sim_pkg::LOSS_CYC && n <= sim_pkg::LOSS_CYC + 4);
      check1(1'b1, safe_osc_enable);
      m_csr |= 'h02;
      wr(sim_pkg::ADDR_CSR, 8'(($urandom & 8'hb1) | 8'h04));
      repeat (3) @(posedge core_clk);
      #1 check1(1'b1, irq_clock_loss);
      @(posedge core_clk);
      global_mask <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 check1(1'b0, irq_clock_loss);
      @(posedge core_clk);
      global_mask <= 1'b0;
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      @(posedge core_clk);
      wait_mode <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 check1(1'b1, wake_from_wait);
      @(posedge core_clk);
      wait_mode <= 1'b0;
      halt_mode <= 1'b1;
      osc_run <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 check1(1'b0, safe_osc_enable);
      check1(1'b0, irq_clock_loss);
      repeat (40) @(posedge core_clk);
      halt_mode <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 check1(1'b1, safe_osc_enable);
      check1(1'b1, irq_clock_loss);
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (cpu_clk_on_safe !== 1'b0 && n < 100);
      check1(1'b1, n >= 24 && n < 100);
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      m_csr &= ~'h02;
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      check1(1'b0, irq_clock_loss);
      test_done("clock_loss");

      wr(sim_pkg::ADDR_CSR, 8'h40);
      @(posedge core_clk);
      opt_uvd_enable <= 1'b0;
      vdd_low <= 1'b1;
      repeat (6) @(posedge core_clk);
      #1 check1(1'b0, irq_supply_warn);
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      @(posedge core_clk);
      opt_uvd_enable <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1 check1(1'b1, irq_supply_warn);
      m_csr |= 'h20;
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      pulse_isr();
      repeat (3) @(posedge core_clk);
      #1 check1(1'b0, irq_supply_warn);
      @(posedge core_clk);
      vdd_low <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1 check1(1'b1, irq_supply_warn);
      m_csr &= ~'h20;
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      @(posedge core_clk);
      halt_mode <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 check1(1'b0, irq_supply_warn);
      @(posedge core_clk);
      halt_mode <= 1'b0;
      wait_mode <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 check1(1'b1, wake_from_wait);
      @(posedge core_clk);
      wait_mode <= 1'b0;
      global_mask <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 check1(1'b0, irq_supply_warn);
      @(posedge core_clk);
      global_mask <= 1'b0;
      pulse_isr();
      wr(sim_pkg::ADDR_CSR, 8'h00);
      test_done("supply_warning");

      for (int i = 0; i < 5; i++) begin
         do_reset(cause_tab[i][1], cause_tab[i][0]);
         rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      end
      wr(sim_pkg::ADDR_CSR, 8'h00);
      rd_chk(sim_pkg::ADDR_CSR, m_csr[7:0]);
      test_done("reset_cause");
      end_sim();
   end
endmodule : sim_top_test
